// ==== cpms_pkg.sv ====
// Purpose: shared constants and types for the codec power and mute sequencer
// Assumes: 10 MHz pclk, APB with 32-bit data, one register per aligned word
// Notes:   byte address of a register is four times its index
package cpms_pkg;

  // register indices; the byte address is index * 4
  localparam logic [2:0] IDX_POWER    = 3'h0;
  localparam logic [2:0] IDX_ADC_IN   = 3'h1;
  localparam logic [2:0] IDX_ADC_CLK  = 3'h2;
  localparam logic [2:0] IDX_DAC_CLK  = 3'h3;
  localparam logic [2:0] IDX_CONTROL  = 3'h4;
  localparam logic [2:0] IDX_STATUS   = 3'h5;

  // writable bits and reset values per register
  localparam logic [7:0] MASK_POWER   = 8'h03;
  localparam logic [7:0] MASK_ADC_IN  = 8'h03;
  localparam logic [7:0] MASK_ADC_CLK = 8'h16;
  localparam logic [7:0] MASK_DAC_CLK = 8'h7F;
  localparam logic [7:0] MASK_CONTROL = 8'h03;
  localparam logic [7:0] RST_POWER    = 8'h00;
  localparam logic [7:0] RST_ADC_IN   = 8'h00;
  localparam logic [7:0] RST_ADC_CLK  = 8'h00;
  localparam logic [7:0] RST_DAC_CLK  = 8'h04;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // field positions
  localparam int BIT_ADC_POWER   = 0;
  localparam int BIT_DAC_POWER   = 1;
  localparam int BIT_SOFT_MUTE   = 0;
  localparam int BIT_DFS_LO      = 4;
  localparam int BIT_DFS_HI      = 5;
  localparam int BIT_AUTO_SPEED  = 6;
  localparam int BIT_PIN_MODE    = 0;
  localparam int BIT_ADC_MASTER  = 1;

  // timing, in the units printed, and cycle counts derived from them
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PUMP_UP_NS      = 1300000;
  localparam int PUMP_UP_CYC     = (PUMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_LOST_NS     = 51200;
  localparam int CLK_LOST_CYC    = CLK_LOST_NS / CLK_PERIOD_NS;

  // frame counts
  localparam logic [11:0] ADC_VALID_FRAMES = 12'hA50;  // 2640
  localparam logic [11:0] ADC_INIT_FRAMES  = 12'h210;  // 528
  localparam logic [11:0] REF_SETTLE_FRAMES = 12'h800; // 2048
  localparam logic [11:0] DAC_INIT_BASE    = 12'h060;  // 6 x 8 x 2
  localparam logic [10:0] MUTE_FULL        = 11'h400;  // 1024 steps
  localparam logic [9:0]  RATIO_NORMAL_MIN = 10'h1C0;  // 448 master edges
  localparam logic [9:0]  RATIO_DOUBLE_MIN = 10'h0E0;  // 224 master edges

  typedef enum logic [1:0] {SPEED_NORMAL, SPEED_DOUBLE, SPEED_QUAD} cpms_speed_t;
  typedef enum {SIDE_OFF, SIDE_WAIT, SIDE_INIT, SIDE_RUN} cpms_side_t;

  // the three serial clocks of one port
  typedef struct packed {
    logic master;
    logic frame;
    logic bitclk;
  } cpms_clk_t;

endpackage : cpms_pkg

// ==== cpms_sequencer.sv ====
// Purpose: power-up, reset and soft mute sequencing of a stereo codec
// Assumes: pins and serial clocks are asynchronous to pclk and are synchronised
// Notes:   link clocks are sampled, so they must be well below pclk / 2
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module cpms_sequencer #(
  parameter int PUMP_CYC = cpms_pkg::PUMP_UP_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              adc_reset_n_pin,
  input  wire logic              dac_reset_n_pin,
  input  wire cpms_pkg::cpms_clk_t adc_clocks,
  input  wire cpms_pkg::cpms_clk_t dac_clocks,
  output logic                   pump_enable,
  output logic                   adc_analog_ready,
  output logic                   adc_out_valid,
  output logic                   dac_out_valid,
  output logic      [10:0]       mute_atten,
  output cpms_pkg::cpms_speed_t  dac_speed
);

  // --- synchronisers: two flops per pin, a third stage for edges
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      prev  <= 8'h00;
    end else begin
      sync1 <= {adc_reset_n_pin, dac_reset_n_pin, adc_clocks, dac_clocks};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  logic       adc_rst_n;
  logic       dac_rst_n;
  logic [2:0] adc_rise;
  logic [2:0] dac_rise;
  assign adc_rst_n = sync2[7];
  assign dac_rst_n = sync2[6];
  assign adc_rise  = sync2[5:3] & ~prev[5:3];
  assign dac_rise  = sync2[2:0] & ~prev[2:0];

  // --- registers
  logic [7:0] reg_power;
  logic [7:0] reg_adc_in;
  logic [7:0] reg_adc_clk;
  logic [7:0] reg_dac_clk;
  logic [7:0] reg_control;
  logic       wr_en;
  logic [2:0] idx;
  logic       idx_ok;
  assign idx    = paddr[4:2];
  assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) && (idx <= cpms_pkg::IDX_STATUS);
  assign wr_en  = psel && penable && pready && pwrite && idx_ok;

  // pin mode ignores the power bits, soft mute and auto speed; the DFS bits and adc master bit still apply
  logic pin_mode;
  logic adc_pwr;
  logic dac_pwr;
  logic soft_mute;
  assign pin_mode  = reg_control[cpms_pkg::BIT_PIN_MODE];
  assign adc_pwr   = pin_mode | reg_power[cpms_pkg::BIT_ADC_POWER];
  assign dac_pwr   = pin_mode | reg_power[cpms_pkg::BIT_DAC_POWER];
  assign soft_mute = !pin_mode && reg_dac_clk[cpms_pkg::BIT_SOFT_MUTE];

  // power bits: each half cleared by its own reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_power <= cpms_pkg::RST_POWER;
    end else begin
      if (wr_en && idx == cpms_pkg::IDX_POWER) begin
        reg_power <= pwdata[7:0] & cpms_pkg::MASK_POWER;
      end
      if (!adc_rst_n) begin
        reg_power[cpms_pkg::BIT_ADC_POWER] <= 1'b0;
      end
      if (!dac_rst_n) begin
        reg_power[cpms_pkg::BIT_DAC_POWER] <= 1'b0;
      end
    end
  end

  // adc registers; the power bit never touches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_adc_in  <= cpms_pkg::RST_ADC_IN;
      reg_adc_clk <= cpms_pkg::RST_ADC_CLK;
    end else if (!adc_rst_n) begin
      reg_adc_in  <= cpms_pkg::RST_ADC_IN;
      reg_adc_clk <= cpms_pkg::RST_ADC_CLK;
    end else if (wr_en && idx == cpms_pkg::IDX_ADC_IN) begin
      reg_adc_in  <= pwdata[7:0] & cpms_pkg::MASK_ADC_IN;
    end else if (wr_en && idx == cpms_pkg::IDX_ADC_CLK) begin
      reg_adc_clk <= pwdata[7:0] & cpms_pkg::MASK_ADC_CLK;
    end
  end

  // dac register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_dac_clk <= cpms_pkg::RST_DAC_CLK;
    end else if (!dac_rst_n) begin
      reg_dac_clk <= cpms_pkg::RST_DAC_CLK;
    end else if (wr_en && idx == cpms_pkg::IDX_DAC_CLK) begin
      reg_dac_clk <= pwdata[7:0] & cpms_pkg::MASK_DAC_CLK;
    end
  end

  // control register returns to default only when both pins are low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_control <= cpms_pkg::RST_CONTROL;
    end else if (!adc_rst_n && !dac_rst_n) begin
      reg_control <= cpms_pkg::RST_CONTROL;
    end else if (wr_en && idx == cpms_pkg::IDX_CONTROL) begin
      reg_control <= pwdata[7:0] & cpms_pkg::MASK_CONTROL;
    end
  end

  // --- clock presence: timeout on pclk, which never stops
  function automatic logic [9:0] age_next(input logic [9:0] age, input logic edge_seen);
    if (edge_seen) begin
      age_next = 10'h000;
    end else if (age < 10'(cpms_pkg::CLK_LOST_CYC)) begin
      age_next = age + 10'h001;
    end else begin
      age_next = age;
    end
  endfunction : age_next

  logic [9:0] adc_age [3];
  logic [9:0] dac_age [3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        adc_age[i] <= 10'(cpms_pkg::CLK_LOST_CYC);
        dac_age[i] <= 10'(cpms_pkg::CLK_LOST_CYC);
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        adc_age[i] <= age_next(adc_age[i], adc_rise[i]);
        dac_age[i] <= age_next(dac_age[i], dac_rise[i]);
      end
    end
  end

  logic adc_master_mode;
  logic adc_clk_ok;
  logic dac_clk_ok;
  logic adc_req;
  logic dac_req;
  assign adc_master_mode = reg_control[cpms_pkg::BIT_ADC_MASTER];
  // master mode needs only the master clock; slave mode needs all three
  assign adc_clk_ok = (adc_age[2] < 10'(cpms_pkg::CLK_LOST_CYC)) &&
                      (adc_master_mode || ((adc_age[1] < 10'(cpms_pkg::CLK_LOST_CYC)) &&
                                           (adc_age[0] < 10'(cpms_pkg::CLK_LOST_CYC))));
  assign dac_clk_ok = (dac_age[2] < 10'(cpms_pkg::CLK_LOST_CYC)) &&
                      (dac_age[1] < 10'(cpms_pkg::CLK_LOST_CYC)) &&
                      (dac_age[0] < 10'(cpms_pkg::CLK_LOST_CYC));
  assign adc_req = adc_rst_n && adc_pwr && adc_clk_ok;
  assign dac_req = dac_rst_n && dac_pwr && dac_clk_ok;

  // --- charge pump: on with either side, off only when both drop
  logic [15:0] pump_cnt;
  logic        pump_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_enable <= 1'b0;
      pump_cnt    <= 16'h0000;
      pump_ready  <= 1'b0;
    end else begin
      pump_enable <= adc_req || dac_req;
      if (!pump_enable) begin
        pump_cnt   <= 16'h0000;
        pump_ready <= 1'b0;
      end else if (pump_cnt < 16'(PUMP_CYC)) begin
        pump_cnt   <= pump_cnt + 16'h0001;
      end else begin
        pump_ready <= 1'b1;
      end
    end
  end

  // --- speed mode: manual bits or measured master/frame ratio
  logic [9:0] ratio_cnt;
  logic [9:0] ratio;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_cnt <= 10'h000;
      ratio     <= 10'h000;
    end else if (dac_rise[1]) begin
      ratio     <= ratio_cnt;
      ratio_cnt <= 10'h000;
    end else if (dac_rise[2] && ratio_cnt != 10'h3FF) begin
      ratio_cnt <= ratio_cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_speed <= cpms_pkg::SPEED_NORMAL;
    end else if (reg_dac_clk[cpms_pkg::BIT_AUTO_SPEED] && !pin_mode) begin
      if (ratio >= cpms_pkg::RATIO_NORMAL_MIN) begin
        dac_speed <= cpms_pkg::SPEED_NORMAL;
      end else if (ratio >= cpms_pkg::RATIO_DOUBLE_MIN) begin
        dac_speed <= cpms_pkg::SPEED_DOUBLE;
      end else begin
        dac_speed <= cpms_pkg::SPEED_QUAD;
      end
    end else if (reg_dac_clk[cpms_pkg::BIT_DFS_HI]) begin
      dac_speed <= cpms_pkg::SPEED_QUAD;
    end else if (reg_dac_clk[cpms_pkg::BIT_DFS_LO]) begin
      dac_speed <= cpms_pkg::SPEED_DOUBLE;
    end else begin
      dac_speed <= cpms_pkg::SPEED_NORMAL;
    end
  end

  // --- adc side sequence
  cpms_pkg::cpms_side_t adc_state;
  logic [11:0]          adc_frames;
  logic [11:0]          ref_frames;
  logic                 adc_start;
  assign adc_start = adc_master_mode ? adc_rise[2] : adc_rise[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_state  <= cpms_pkg::SIDE_OFF;
      adc_frames <= 12'h000;
    end else if (!adc_req) begin
      adc_state  <= cpms_pkg::SIDE_OFF;
      adc_frames <= 12'h000;
    end else begin
      case (adc_state)
        cpms_pkg::SIDE_OFF: adc_state <= cpms_pkg::SIDE_WAIT;
        cpms_pkg::SIDE_WAIT: begin
          if (pump_ready && adc_start) begin
            adc_state <= cpms_pkg::SIDE_INIT;
          end
        end
        cpms_pkg::SIDE_INIT: begin
          if (adc_rise[1]) begin
            adc_frames <= adc_frames + 12'h001;
          end
          if (adc_frames >= cpms_pkg::ADC_VALID_FRAMES) begin
            adc_state <= cpms_pkg::SIDE_RUN;
          end
        end
        cpms_pkg::SIDE_RUN: adc_state <= cpms_pkg::SIDE_RUN;
        default: adc_state <= cpms_pkg::SIDE_OFF;
      endcase
    end
  end

  // reference settling counted in adc frames once the pump is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_frames <= 12'h000;
    end else if (!pump_ready) begin
      ref_frames <= 12'h000;
    end else if (adc_rise[1] && ref_frames < cpms_pkg::REF_SETTLE_FRAMES) begin
      ref_frames <= ref_frames + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_analog_ready <= 1'b0;
      adc_out_valid    <= 1'b0;
    end else begin
      adc_analog_ready <= adc_req && adc_state != cpms_pkg::SIDE_OFF && adc_state != cpms_pkg::SIDE_WAIT
                          && adc_frames >= cpms_pkg::ADC_INIT_FRAMES;
      // serial output held low until valid and the reference has settled
      adc_out_valid    <= adc_req && adc_state == cpms_pkg::SIDE_RUN
                          && ref_frames >= cpms_pkg::REF_SETTLE_FRAMES;
    end
  end

  // --- dac side sequence; init length scales with speed
  cpms_pkg::cpms_side_t dac_state;
  logic [11:0]          dac_frames;
  logic [11:0]          dac_init_len;
  assign dac_init_len = (dac_speed == cpms_pkg::SPEED_QUAD)   ? {cpms_pkg::DAC_INIT_BASE[9:0], 2'b00} :
                        (dac_speed == cpms_pkg::SPEED_DOUBLE) ? {cpms_pkg::DAC_INIT_BASE[10:0], 1'b0} :
                        cpms_pkg::DAC_INIT_BASE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_state  <= cpms_pkg::SIDE_OFF;
      dac_frames <= 12'h000;
    end else if (!dac_req) begin
      dac_state  <= cpms_pkg::SIDE_OFF;
      dac_frames <= 12'h000;
    end else begin
      case (dac_state)
        cpms_pkg::SIDE_OFF: dac_state <= cpms_pkg::SIDE_WAIT;
        cpms_pkg::SIDE_WAIT: begin
          if (pump_ready && dac_rise[1]) begin
            dac_state <= cpms_pkg::SIDE_INIT;
          end
        end
        cpms_pkg::SIDE_INIT: begin
          if (dac_rise[1]) begin
            dac_frames <= dac_frames + 12'h001;
          end
          if (dac_frames >= dac_init_len) begin
            dac_state <= cpms_pkg::SIDE_RUN;
          end
        end
        cpms_pkg::SIDE_RUN: dac_state <= cpms_pkg::SIDE_RUN;
        default: dac_state <= cpms_pkg::SIDE_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_out_valid <= 1'b0;
    end else begin
      dac_out_valid <= dac_req && dac_state == cpms_pkg::SIDE_RUN;
    end
  end

  // --- soft mute ramp: one step per frame, slower at higher speed
  // reversing mid-ramp needs no state of its own: the level is the state
  logic [1:0] step_pre;
  logic       step;
  logic [1:0] step_mask;
  assign step_mask = (dac_speed == cpms_pkg::SPEED_QUAD)   ? 2'h3 :
                     (dac_speed == cpms_pkg::SPEED_DOUBLE) ? 2'h1 : 2'h0;
  assign step = dac_rise[1] && ((step_pre & step_mask) == 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pre   <= 2'h0;
      mute_atten <= 11'h000;
    end else begin
      if (dac_rise[1]) begin
        step_pre <= step_pre + 2'h1;
      end
      if (step && soft_mute && mute_atten < cpms_pkg::MUTE_FULL) begin
        mute_atten <= mute_atten + 11'h001;
      end else if (step && !soft_mute && mute_atten != 11'h000) begin
        mute_atten <= mute_atten - 11'h001;
      end
    end
  end

  // --- apb: one wait state, registered answer
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      cpms_pkg::IDX_POWER:   rd_byte = reg_power;
      cpms_pkg::IDX_ADC_IN:  rd_byte = reg_adc_in;
      cpms_pkg::IDX_ADC_CLK: rd_byte = reg_adc_clk;
      cpms_pkg::IDX_DAC_CLK: rd_byte = reg_dac_clk;
      cpms_pkg::IDX_CONTROL: rd_byte = reg_control;
      cpms_pkg::IDX_STATUS:  rd_byte = {1'b0, dac_speed, dac_out_valid, adc_out_valid,
                                        adc_analog_ready, pump_ready, pump_enable};
      default:               rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (!idx_ok || (pwrite && idx == cpms_pkg::IDX_STATUS));
      prdata  <= (psel && penable && !pready && !pwrite && idx_ok) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // --- assertions
  property p_pump_on;
    @(posedge pclk) disable iff (!presetn) (adc_req || dac_req) |=> pump_enable;
  endproperty
  a_pump_on: assert property (p_pump_on) else $error("pump not on with active side");

  property p_pin_mode;
    @(posedge pclk) disable iff (!presetn)
      pin_mode && dac_rst_n && dac_clk_ok && !reg_power[cpms_pkg::BIT_DAC_POWER] |=> pump_enable;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode did not ignore power bit");

  property p_side_after_pump;
    @(posedge pclk) disable iff (!presetn) (dac_state == cpms_pkg::SIDE_INIT) |-> pump_ready;
  endproperty
  a_side_after_pump: assert property (p_side_after_pump) else $error("dac started before pump");

  property p_mute_down;
    @(posedge pclk) disable iff (!presetn)
      step && soft_mute && mute_atten < cpms_pkg::MUTE_FULL |=> mute_atten == $past(mute_atten) + 11'h001;
  endproperty
  a_mute_down: assert property (p_mute_down) else $error("mute ramp did not advance");

  property p_mute_up;
    @(posedge pclk) disable iff (!presetn)
      step && !soft_mute && mute_atten != 11'h000 |=> mute_atten == $past(mute_atten) - 11'h001;
  endproperty
  a_mute_up: assert property (p_mute_up) else $error("mute release did not step back");

  property p_adc_pin_reset;
    @(posedge pclk) disable iff (!presetn)
      !adc_rst_n |=> reg_adc_in == cpms_pkg::RST_ADC_IN && !reg_power[cpms_pkg::BIT_ADC_POWER];
  endproperty
  a_adc_pin_reset: assert property (p_adc_pin_reset) else $error("adc registers not reset");

  property p_both_reset;
    @(posedge pclk) disable iff (!presetn) !adc_rst_n && !dac_rst_n |=> ##1 !pump_enable;
  endproperty
  a_both_reset: assert property (p_both_reset) else $error("pump on under full reset");

  property p_adc_valid_late;
    @(posedge pclk) disable iff (!presetn)
      adc_out_valid |-> $past(adc_frames) >= cpms_pkg::ADC_VALID_FRAMES;
  endproperty
  a_adc_valid_late: assert property (p_adc_valid_late) else $error("adc valid too early");

  property p_keep_regs;
    @(posedge pclk) disable iff (!presetn)
      $fell(reg_power[cpms_pkg::BIT_DAC_POWER]) && dac_rst_n && $past(dac_rst_n) |-> $stable(reg_dac_clk);
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("power bit changed dac register");

  property p_pump_off;
    @(posedge pclk) disable iff (!presetn) pump_enable && !adc_req && !dac_req |=> !pump_enable;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump stayed on with sides idle");

  c_full_mute: cover property (@(posedge pclk) disable iff (!presetn) mute_atten == cpms_pkg::MUTE_FULL);
  c_adc_valid: cover property (@(posedge pclk) disable iff (!presetn) $rose(adc_out_valid));
  c_dac_valid: cover property (@(posedge pclk) disable iff (!presetn) $rose(dac_out_valid));
  c_reverse:   cover property (@(posedge pclk) disable iff (!presetn)
                               $fell(soft_mute) && mute_atten != 11'h000 && mute_atten < cpms_pkg::MUTE_FULL);

endmodule : cpms_sequencer

// ==== cpms_host_model.sv ====
// Purpose: host side, reset pins and serial clocks
// Assumes: 800 ns master clock, frame is master / 4
// Notes:   clocks stand still while a side is stopped
`timescale 1ns/1ps
module cpms_host_model (
  input  wire logic           dac_run,
  input  wire logic           adc_rel,
  input  wire logic           dac_rel,
  output logic                adc_reset_n_pin,
  output logic                dac_reset_n_pin,
  output cpms_pkg::cpms_clk_t adc_clocks,
  output cpms_pkg::cpms_clk_t dac_clocks
);
  logic [1:0] dc;
  // pins low from supply; release lags so low time is long
  initial {adc_reset_n_pin, dac_reset_n_pin} = 2'b00;
  always @(adc_rel) adc_reset_n_pin <= #430 adc_rel;
  always @(dac_rel) dac_reset_n_pin <= #430 dac_rel;
  // dac clocks, off the pclk edges; adc clocks stay quiet
  initial begin
    {adc_clocks, dac_clocks, dc} = '0;
    #37;
    forever begin
      #400;
      if (dac_run) begin
        dac_clocks.master = ~dac_clocks.master;
        dc = dc + {1'b0, dac_clocks.master};
        dac_clocks.frame = dc[1];
        dac_clocks.bitclk = dac_clocks.master;
      end
    end
  end
endmodule : cpms_host_model

// ==== codec_power_mute_sequencer_test.sv ====
// Purpose: self-checking bench for the sequencer
// Assumes: 10 MHz pclk, pump count cut to 20
// Notes:   apb answers are queued, a monitor compares
`timescale 1ns/1ps
module codec_power_mute_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rnd;
  logic [31:0] pwdata, prdata;
  logic a_n, d_n, pump, a_rdy, a_ok, d_ok, a_rel, d_rel, run;
  logic [10:0] att, lvl;
  cpms_pkg::cpms_clk_t ack, dck;
  cpms_pkg::cpms_speed_t spd;
  logic [8:0] q[$];
  int miscompares, checks_done, n;
  cpms_sequencer #(.PUMP_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_reset_n_pin(a_n), .dac_reset_n_pin(d_n),
    .adc_clocks(ack), .dac_clocks(dck), .pump_enable(pump), .adc_analog_ready(a_rdy),
    .adc_out_valid(a_ok), .dac_out_valid(d_ok), .mute_atten(att), .dac_speed(spd));
  cpms_host_model u_host (.dac_run(run), .adc_rel(a_rel), .dac_rel(d_rel),
    .adc_reset_n_pin(a_n), .dac_reset_n_pin(d_n), .adc_clocks(ack), .dac_clocks(dck));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // one apb transfer; the answer is noted for the monitor
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] e, input logic er);
    int k;
    k = 0;
    @(posedge pclk);
    q.push_back({e, er});
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20) chk("apb wait", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // oldest note against each answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) chk("apb extra", 0, 1);
      else chk("apb", {23'h0, q.pop_front()}, {prdata[30:0], pslverr});
    end
  end
  initial begin
    #5000000;
    miscompares++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, run, a_rel, d_rel, presetn} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    n = $urandom(32'h66DE07FF);
    rnd = 8'($urandom());
    apb(8'h00, 0, 0, 8'h00, 0);
    apb(8'h0C, 0, 0, 8'h04, 0);
    apb(8'h18, 0, 0, 8'h00, 1); // unmapped
    apb(8'h14, 1, 8'hFF, 8'h00, 1); // read-only
    {a_rel, d_rel} <= 2'b11;
    repeat (10) @(posedge pclk);
    apb(8'h04, 1, rnd, 8'h00, 0);
    apb(8'h00, 1, 8'h02, 8'h00, 0);
    repeat (20) @(posedge pclk);
    chk("pump idle", 0, pump);
    run <= 1'b1;
    for (n = 0; n < 1000 && pump !== 1'b1; n++) @(posedge pclk);
    chk("pump on", 1, pump);
    for (n = 0; n < 5000 && d_ok !== 1'b1; n++) @(posedge pclk);
    chk("dac init", 1, n >= 3000 && d_ok === 1'b1);
    chk("adc held low", 0, {a_rdy, a_ok});
    chk("manual speed", cpms_pkg::SPEED_NORMAL, spd);
    // mute up, reversed mid-ramp, back to zero
    apb(8'h0C, 1, 8'h05, 8'h00, 0);
    repeat (3200) @(posedge pclk);
    chk("mute up", 1, att >= 90 && att <= 110);
    lvl = att;
    apb(8'h0C, 1, 8'h04, 8'h00, 0);
    repeat (320) @(posedge pclk);
    chk("mute back", 1, att + 7 <= lvl && att + 12 >= lvl);
    for (n = 0; n < 5000 && att !== 11'h000; n++) @(posedge pclk);
    chk("mute zero", 0, att);
    // auto speed: a few master rises per frame reads as quad, so one step per 4 frames
    apb(8'h0C, 1, 8'h4D, 8'h00, 0);
    repeat (3200) @(posedge pclk);
    chk("auto speed", cpms_pkg::SPEED_QUAD, spd);
    chk("quad ramp", 1, att >= 22 && att <= 28);
    apb(8'h0C, 1, 8'h4C, 8'h00, 0);
    for (n = 0; n < 5000 && att !== 11'h000; n++) @(posedge pclk);
    chk("quad release", 0, att);
    apb(8'h00, 1, 8'h00, 8'h00, 0);
    repeat (5) @(posedge pclk);
    chk("dac off", 0, d_ok);
    chk("pump off", 0, pump);
    apb(8'h04, 0, 0, rnd & 8'h03, 0);
    apb(8'h0C, 0, 0, 8'h4C, 0);
    apb(8'h00, 1, 8'h02, 8'h00, 0);
    d_rel <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(8'h00, 0, 0, 8'h00, 0);
    apb(8'h04, 0, 0, rnd & 8'h03, 0);
    apb(8'h0C, 0, 0, 8'h04, 0);
    // pin mode powers up on clocks alone
    apb(8'h10, 1, 8'h01, 8'h00, 0);
    d_rel <= 1'b1;
    for (n = 0; n < 1000 && pump !== 1'b1; n++) @(posedge pclk);
    chk("pin mode", 1, pump);
    run <= 1'b0;
    for (n = 0; n < 800 && pump !== 1'b0; n++) @(posedge pclk);
    // last frame rise may precede the stop by up to one frame period
    chk("clock lost", 1, n >= cpms_pkg::CLK_LOST_CYC - 40 && pump === 1'b0);
    final_report();
  end
endmodule : codec_power_mute_sequencer_test
